// ---- rtl/tick_pll_ctrl.sv ----
/*
  periodic tick divider with binary or decimal prescale and modulus,
  plus pll frequency modulation control, on an ahb-lite slave.
  assumes rc and crystal clocks arrive as one-cycle enables on hclk,
  and protection, clock select, stop and status levels are synchronous.
*/
`timescale 1ns/10ps
`include "tick_pll_defines.svh"
module tick_pll_ctrl (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output      logic [31:0]             hrdata,
  output      logic                    hreadyout,
  output      logic                    hresp,
  input  wire logic                    register_protect,
  input  wire logic                    loop_clock_select,
  input  wire logic                    tick_clock_select,
  input  wire logic                    pseudo_halt_select,
  input  wire logic                    stop_mode,
  input  wire logic                    tick_irq_enable,
  input  wire logic                    internal_rc_clock,
  input  wire logic                    crystal_clock,
  input  wire logic                    ref_clock_en,
  output      logic                    status_clear,
  output      tick_pll_pkg::fm_amp_type fm_amplitude,
  output      logic                    fm_step,
  output      logic                    tick_flag,
  output      logic                    tick_irq
);
  import tick_pll_pkg::*;

  logic          wr_pend_r;
  logic          wr_pend_nxt;
  logic [7:0]    waddr_r;
  logic [7:0]    waddr_nxt;
  logic [31:0]   rdata_nxt;
  logic [7:0]    tick_ctrl_r;
  logic [7:0]    tick_ctrl_nxt;
  fm_amp_type    fm_r;
  fm_amp_type    fm_nxt;
  logic          clr_nxt;
  logic [17:0]   pre_cnt_r;
  logic [17:0]   pre_cnt_nxt;
  logic [3:0]    mod_cnt_r;
  logic [3:0]    mod_cnt_nxt;
  logic          sel_d_r;
  logic          sel_d_nxt;
  logic          flag_nxt;
  logic          irq_nxt;
  logic [17:0]   pre_len;
  logic          tick_clear;
  logic          fm_on;
  logic          fm_step_w;
  fm_amp_type    fm_out_nxt;
  logic          step_out_nxt;
  logic          ready_nxt;
  logic          resp_nxt;
  logic          addr_phase;
  logic [7:0]    addr_index;
  logic          wr_tick;
  logic          wr_pll;
  logic          tick_en;
  logic          tick_run;
  logic          restart;
  logic          pre_done;

  // register index of a bus address: the byte address is four times it,
  // since the register offsets are not word multiples themselves
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    reg_index = a[`IDX_MSB:`IDX_LSB];
  endfunction : reg_index

  // read-back word for one register index; unmapped indices read zero
  function automatic logic [31:0] read_word(
    input logic [7:0] ix,
    input fm_amp_type fm,
    input logic [7:0] ctl,
    input logic       flg
  );
    read_word = 32'h00000000;
    case (ix)
      `ADDR_PLL_MOD: begin
        read_word = {26'h0, fm, 4'h0};
      end
      `ADDR_TICK_CTRL: begin
        read_word = {24'h0, ctl};
      end
      `ADDR_TICK_STATUS: begin
        read_word = {31'h0, flg};
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  endfunction : read_word

  // prescale length in input clocks for the current setting
  function automatic logic [17:0] prescale_len(input logic [7:0] c);
    logic [2:0] p;
    p = c[`PRE_MSB:`PRE_LSB];
    prescale_len = 18'h00000;
    if (c[`DEC_BIT]) begin
      case (p)
        3'h0: prescale_len = 18'h003e8;
        3'h1: prescale_len = 18'h007d0;
        3'h2: prescale_len = 18'h01388;
        3'h3: prescale_len = 18'h02710;
        3'h4: prescale_len = 18'h04e20;
        3'h5: prescale_len = 18'h0c350;
        3'h6: prescale_len = 18'h186a0;
        3'h7: prescale_len = 18'h30d40;
        default: prescale_len = 18'h003e8;
      endcase
    end else if (p != `PRE_OFF) begin
      // 001 gives 2^10, each step doubles
      prescale_len = 18'h00001 << (`BIN_BASE_SHIFT + {2'h0, p});
    end
  endfunction : prescale_len

  assign addr_phase = hsel && hready && htrans[1];
  assign addr_index = reg_index(haddr);
  assign wr_tick = wr_pend_r && waddr_r == `ADDR_TICK_CTRL;
  assign wr_pll  = wr_pend_r && waddr_r == `ADDR_PLL_MOD
                   && !register_protect && loop_clock_select;
  assign tick_clear = wr_pend_r && waddr_r == `ADDR_TICK_STATUS
                      && hwdata[0];

  // bus slave: zero wait states, writes land in the data phase
  always_comb begin
    wr_pend_nxt = addr_phase && hwrite;
    waddr_nxt   = addr_phase ? addr_index : waddr_r;
    rdata_nxt   = 32'h00000000;
    // read data is launched in the address phase so it stands in the
    // data phase without a wait state
    if (addr_phase && !hwrite) begin
      rdata_nxt = read_word(addr_index, fm_r, tick_ctrl_r, tick_flag);
    end
  end

  always_comb begin
    tick_ctrl_nxt = wr_tick ? hwdata[7:0] : tick_ctrl_r;
    fm_nxt  = wr_pll ? fm_amp_type'(hwdata[`FM_HI_BIT:`FM_LO_BIT]) : fm_r;
    clr_nxt = wr_pll;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      waddr_r   <= waddr_nxt;
      hrdata    <= rdata_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ctrl_r  <= `TICK_CTRL_RESET;
      fm_r         <= fm_amp_type'(`PLL_MOD_RESET);
      status_clear <= 1'b0;
    end else begin
      tick_ctrl_r  <= tick_ctrl_nxt;
      fm_r         <= fm_nxt;
      status_clear <= clr_nxt;
    end
  end

  // tick counter
  always_comb begin
    // clock source pick
    tick_en  = tick_clock_select ? crystal_clock : internal_rc_clock;
    // stop freezes the count, except in pseudo halt on the crystal, but does not reset it
    tick_run = tick_en &&
               (!stop_mode || (pseudo_halt_select && tick_clock_select));
    restart  = wr_tick
               || (sel_d_r != tick_clock_select);
    pre_len   = prescale_len(tick_ctrl_r);
    pre_done  = pre_cnt_r == pre_len - 18'h00001;
    sel_d_nxt = tick_clock_select;
    pre_cnt_nxt = pre_cnt_r;
    mod_cnt_nxt = mod_cnt_r;
    flag_nxt    = tick_flag;
    if (tick_clear) begin
      flag_nxt = 1'b0;
    end
    if (restart || pre_len == 18'h00000) begin
      pre_cnt_nxt = 18'h00000;
      mod_cnt_nxt = 4'h0;
    end else if (tick_run) begin
      if (!pre_done) begin
        pre_cnt_nxt = pre_cnt_r + 18'h00001;
      end else begin
        pre_cnt_nxt = 18'h00000;
        if (mod_cnt_r == tick_ctrl_r[`MOD_MSB:`MOD_LSB]) begin
          mod_cnt_nxt = 4'h0;
          flag_nxt    = 1'b1; // set wins over clear
        end else begin
          mod_cnt_nxt = mod_cnt_r + 4'h1;
        end
      end
    end
    // irq follows the flag in the same edge; the enable lags by one
    irq_nxt = flag_nxt && tick_irq_enable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 18'h00000;
      mod_cnt_r <= 4'h0;
      sel_d_r   <= 1'b0;
      tick_flag <= 1'b0;
      tick_irq  <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      mod_cnt_r <= mod_cnt_nxt;
      sel_d_r   <= sel_d_nxt;
      tick_flag <= flag_nxt;
      tick_irq  <= irq_nxt;
    end
  end

  assign fm_on = fm_r != fm_off_type_v;

  fm_rate_divider u_fm_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .fm_on   (fm_on),
    .ref_en  (ref_clock_en),
    .fm_step (fm_step_w)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fm_amplitude <= fm_off_type_v;
      fm_step      <= 1'b0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      fm_amplitude <= fm_out_nxt;
      fm_step      <= step_out_nxt;
      hreadyout    <= ready_nxt;
      hresp        <= resp_nxt;
    end
  end

  // output stage: every top output leaves from a flip-flop
  always_comb begin
    fm_out_nxt   = fm_r;
    step_out_nxt = fm_step_w;
    // every register answers at once, so the slave never stalls or errs
    ready_nxt    = 1'b1;
    resp_nxt     = 1'b0;
  end
endmodule : tick_pll_ctrl

// ---- common/tick_pll_defines.svh ----
/*
  constants for the periodic tick divider and the pll modulation control:
  register offsets, field positions, reset values and prescale figures.
  assumes inclusion by bare name from the rtl files.
*/
`ifndef TICK_PLL_DEFINES_SVH
`define TICK_PLL_DEFINES_SVH
`define ADDR_PLL_MOD      8'h3a
`define ADDR_TICK_CTRL    8'h3b
`define ADDR_TICK_STATUS  8'h3c
`define IDX_MSB           9
`define IDX_LSB           2
`define TICK_CTRL_RESET   8'h00
`define PLL_MOD_RESET     2'h0
`define FM_HI_BIT         5
`define FM_LO_BIT         4
`define DEC_BIT           7
`define PRE_MSB           6
`define PRE_LSB           4
`define MOD_MSB           3
`define MOD_LSB           0
`define FM_REF_DIV        5'h10
`define BIN_BASE_SHIFT    5'h09
`define PRE_OFF           3'h0
`endif

// ---- common/tick_pll_pkg.sv ----
/*
  types shared by the tick and pll modulation block.
  assumes the defines header is on the include path.
*/
package tick_pll_pkg;
  typedef enum logic [1:0] {
    fm_off_type_v = 2'h0,
    fm_1pct       = 2'h1,
    fm_2pct       = 2'h2,
    fm_4pct       = 2'h3
  } fm_amp_type;
  typedef enum logic [1:0] {
    bus_idle   = 2'h0,
    bus_data   = 2'h1
  } bus_state_type;
endpackage : tick_pll_pkg

// ---- rtl/fm_rate_divider.sv ----
/*
  modulation rate divider: one enable pulse every sixteen reference
  enable pulses while modulation is on.
  assumes ref_en is a one-cycle enable at the pll reference rate.
*/
`timescale 1ns/10ps
`include "tick_pll_defines.svh"
module fm_rate_divider (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fm_on,
  input  wire logic       ref_en,
  output      logic       fm_step
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       step_nxt;
  always_comb begin
    cnt_nxt  = cnt_r;
    step_nxt = 1'b0;
    if (!fm_on) begin
      cnt_nxt = 5'h00;
    end else if (ref_en) begin
      if (cnt_r == `FM_REF_DIV - 5'h01) begin
        cnt_nxt  = 5'h00;
        step_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= 5'h00;
      fm_step <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      fm_step <= step_nxt;
    end
  end
endmodule : fm_rate_divider

// ---- tb/tick_pll_props.sv ----
/* assertions on the tick_pll_ctrl ports.
   assumes register byte addresses are four times the register index. */
`timescale 1ns/10ps
module tick_pll_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        register_protect,
  input wire logic        loop_clock_select,
  input wire logic        tick_clock_select,
  input wire logic        pseudo_halt_select,
  input wire logic        stop_mode,
  input wire logic        tick_irq_enable,
  input wire logic        status_clear,
  input wire tick_pll_pkg::fm_amp_type fm_amplitude,
  input wire logic        fm_step,
  input wire logic        tick_flag,
  input wire logic        tick_irq
);
  import tick_pll_pkg::*;
  logic      wp_r, wt_r, ws_r;
  wire logic go = hsel && hready && htrans[1] && hwrite;
  wire logic ok = wp_r && !register_protect && loop_clock_select;
  // data-phase markers for writes to the three registers
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {wp_r, wt_r, ws_r} <= 3'h0;
    else
      {wp_r, wt_r, ws_r} <= {go && haddr == 32'he8,
        go && haddr == 32'hec, go && haddr == 32'hf0};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_pll_taken: assert property (ok |=> status_clear
    ##1 fm_amplitude == $past(hwdata[5:4], 2)) else $error("pll write lost");
  chk_pll_guard: assert property (
    (status_clear -> $past(ok)) && ($changed(fm_amplitude) -> $past(ok, 2)))
    else $error("pll change without accepted write");
  chk_fm_rate: assert property (
    fm_step |=> !fm_step [*8]) else $error("fm step too close");
  chk_irq_follow: assert property (
    tick_irq == (tick_flag && $past(tick_irq_enable)))
    else $error("irq does not follow flag");
  chk_flag_sticky: assert property (
    tick_flag && !(ws_r && hwdata[0]) |=> tick_flag)
    else $error("flag dropped");
  chk_tick_restart: assert property (
    wt_r && !tick_flag ##1 !tick_flag |=> !tick_flag [*8])
    else $error("tick fired right after control write");
  chk_stop_halt: assert property (
    stop_mode && !(pseudo_halt_select && tick_clock_select) && !tick_flag
    |=> !tick_flag) else $error("tick ran in stop");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  cover property (ok);
  cover property (fm_step);
  cover property ($rose(tick_flag));
endmodule : tick_pll_props
bind tick_pll_ctrl tick_pll_props chk (.*);

// ---- tb/periodic_tick_and_pll_fm_ctrl_test.sv ----
/* bench for tick_pll_ctrl: a table of tick periods, then irq, reset,
   restart, stop and pll cases. assumes a zero-wait ahb-lite slave. */
`timescale 1ns/10ps
module periodic_tick_and_pll_fm_ctrl_test;
  import tick_pll_pkg::*;
  localparam logic [7:0] pll_ix = 8'h3a, tck_ix = 8'h3b, sta_ix = 8'h3c;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tick_irq;
  logic        register_protect, loop_clock_select, tick_clock_select;
  logic        pseudo_halt_select, stop_mode, tick_irq_enable, fm_step;
  logic        internal_rc_clock, crystal_clock, ref_clock_en;
  logic        status_clear, tick_flag;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  fm_amp_type  fm_amplitude;
  wire logic   hready = hreadyout;
  int          miscompares = 0, compares = 0, clears = 0, n;
  logic [7:0]  ctl [5] = '{8'h10, 8'h11, 8'h80, 8'h91, 8'h81};
  logic        src [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int          per [5] = '{1024, 2048, 1000, 4000, 2000};
  tick_pll_ctrl dut (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (status_clear === 1'b1) clears++;
  task automatic check(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] ix, d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  // count is taken from the edge that ends the last write
  task automatic wait_flag(output int k);
    k = 0;
    @(negedge hclk);
    while (tick_flag !== 1'b1) begin
      @(negedge hclk);
      k++;
    end
  endtask : wait_flag
  task automatic arm(input logic [7:0] c, input int w);
    bus(1'b1, sta_ix, 8'h01);
    bus(1'b1, tck_ix, c);
    repeat (w) @(posedge hclk);
  endtask : arm
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #500000;
    miscompares++;
    final_report;
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} <= {7'h42, 64'h0};
    {register_protect, loop_clock_select, tick_clock_select} <= 3'h2;
    {pseudo_halt_select, stop_mode, tick_irq_enable} <= 3'h1;
    {internal_rc_clock, crystal_clock, ref_clock_en, hresetn} <= 4'ha;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      {tick_clock_select, crystal_clock, internal_rc_clock} <=
        {src[i], src[i], !src[i]};
      arm(ctl[i], 0);
      wait_flag(n);
      check(n == per[i] || n == per[i] + 1, "period");
    end
    @(negedge hclk);
    check(tick_irq === 1'b1, "irq missing");
    tick_irq_enable <= 1'b0;
    repeat (2) @(negedge hclk);
    check(tick_irq === 1'b0, "irq not masked");
    {tick_irq_enable, hresetn} <= 2'h2;
    repeat (2) @(posedge hclk);
    check(tick_flag === 1'b0, "flag after reset");
    hresetn <= 1'b1;
    bus(1'b0, tck_ix, 8'h00);
    check(q[7:0] === 8'h00, "control reset value");
    bus(1'b0, 8'h3f, 8'h00);
    check(q === 32'h0, "unmapped read");
    arm(8'h0f, 1100);
    check(tick_flag === 1'b0, "zero prescale ticked");
    arm(8'h10, 600);
    bus(1'b1, tck_ix, 8'h10);
    wait_flag(n);
    check(n == 1024 || n == 1025, "write restart");
    {internal_rc_clock, crystal_clock, tick_clock_select} <= 3'h6;
    arm(8'h10, 600);
    tick_clock_select <= 1'b1;
    wait_flag(n);
    check(n >= 1024 && n <= 1026, "select restart");
    arm(8'h10, 500);
    stop_mode <= 1'b1;
    repeat (1500) @(posedge hclk);
    check(tick_flag === 1'b0, "ran in stop");
    stop_mode <= 1'b0;
    wait_flag(n);
    check(n == 524 || n == 525, "count lost in stop");
    {pseudo_halt_select, stop_mode} <= 2'h3;
    arm(8'h10, 0);
    wait_flag(n);
    check(n == 1024 || n == 1025, "pseudo halt count");
    {stop_mode, register_protect} <= 2'h1;
    bus(1'b1, pll_ix, 8'h30);
    {register_protect, loop_clock_select} <= 2'h0;
    bus(1'b1, pll_ix, 8'h30);
    repeat (2) @(negedge hclk);
    check(fm_amplitude === fm_off_type_v && clears == 0, "guard");
    loop_clock_select <= 1'b1;
    for (int k = 3; k >= 0; k--) begin
      bus(1'b1, pll_ix, 8'(k << 4));
      bus(1'b0, pll_ix, 8'h00);
      check(q[5:4] === 2'(k) && fm_amplitude === fm_amp_type'(k), "fm");
    end
    check(clears == 4, "status clears");
    bus(1'b1, pll_ix, 8'h10);
    @(negedge hclk iff fm_step === 1'b1);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (fm_step !== 1'b1);
    check(n == 16, "fm rate");
    final_report;
  end
endmodule : periodic_tick_and_pll_fm_ctrl_test
